// ---- src/sync_status_overhead_adapt.sv ----
// synchronization status message insertion and extraction in overhead bits 6..8
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module sync_status_overhead_adapt
    import ssm_pkg::*;
#(
    parameter int LOM_CYCLES = `LOM_TIME_US * `REF_CLK_MHZ
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // register bus
    input  wire logic [`AXI_AW-1:0]    s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [`AXI_AW-1:0]    s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // frame timing from the link, asynchronous
    input  wire logic                  frame_clk,
    input  wire logic                  frame_start_tick,
    input  wire logic                  multiframe_start_tick,
    // source side: distribution layer in, overhead bits out
    input  ql_t                        quality_level_in,
    input  wire logic [`CSID_W-1:0]    clock_source_id,
    input  wire logic [`CSID_W-1:0]    remote_clock_source_id,
    output logic [2:0]                 tx_overhead_bits,
    // sink side: overhead bits in, asynchronous
    input  wire logic                  rx_frame_start_tick,
    input  wire logic [2:0]            rx_overhead_bits,
    input  wire logic                  trail_signal_fail,
    // sink side outputs to the distribution layer
    output ql_t                        quality_level_out,
    output logic [`CSID_W-1:0]         sink_clock_source_id,
    output logic [`CSID_W-1:0]         sink_remote_clock_source_id,
    output logic                       server_signal_fail_out,
    output logic                       sync_clock_out,
    output logic                       multiframe_loss_cause,
    output logic                       multiframe_loss_defect,
    output logic                       in_multiframe
);

    // ************************************************************
    // functions
    // ************************************************************

    // word decode shared by read and write paths; 3 means unmapped
    function automatic logic [1:0] reg_decode(input logic [`AXI_AW-1:0] addr);
        logic [1:0] sel;
        sel = 2'd3;
        if (addr == `REG_CTRL) begin
            sel = 2'd0;
        end else if (addr == `REG_CSID) begin
            sel = 2'd1;
        end else if (addr == `REG_STATUS) begin
            sel = 2'd2;
        end
        return sel;
    endfunction

    // quality level to status code; unlisted levels send the all-ones code
    function automatic logic [3:0] ssm_encode(input ql_t ql);
        logic [3:0] code;
        case (ql)
            primary_reference_level: code = `SSM_PRC;
            transit_node_level:      code = `SSM_SSUT;
            local_node_level:        code = `SSM_SSUL;
            equipment_clock_level:   code = `SSM_SEC;
            default:                 code = `SSM_FORCED;
        endcase
        return code;
    endfunction

    // received status code back to a quality level
    function automatic ql_t ssm_decode(input logic [3:0] code);
        ql_t ql;
        case (code)
            `SSM_PRC:  ql = primary_reference_level;
            `SSM_SSUT: ql = transit_node_level;
            `SSM_SSUL: ql = local_node_level;
            `SSM_SEC:  ql = equipment_clock_level;
            default:   ql = quality_unknown;
        endcase
        return ql;
    endfunction

    // ************************************************************
    // state
    // ************************************************************

    localparam logic [`LOM_CNT_W-1:0] LOM_LAST = `LOM_CNT_W'(LOM_CYCLES - 1);

    state_t s_r;
    state_t s_nxt;

    // ************************************************************
    // next state
    // ************************************************************

    // all behaviour in one pass; the frame edge gates every overhead bit sent or taken in, not the loss timer
    always_comb begin
        logic       fedge;
        logic       marker;
        logic       ssm_dis;
        logic       ql_en;
        logic       supp;
        logic       forced;
        logic [1:0] fidx;
        logic [3:0] new_code;
        logic [3:0] code_use;
        logic       new_mark;
        logic       sink_en;
        logic       mark_en;
        logic [1:0] ind;
        logic       b8;
        logic       seq_ok;
        logic [3:0] rx_code;
        fedge    = 1'b0;
        marker   = 1'b0;
        ssm_dis  = 1'b0;
        ql_en    = 1'b0;
        supp     = 1'b0;
        forced   = 1'b0;
        fidx     = 2'd0;
        new_code = 4'h0;
        code_use = 4'h0;
        new_mark = 1'b0;
        sink_en  = 1'b0;
        mark_en  = 1'b0;
        ind      = 2'd0;
        b8       = 1'b0;
        seq_ok   = 1'b0;
        rx_code  = 4'h0;
        s_nxt    = s_r;

        // two-stage synchronisers; only stage two is looked at below
        s_nxt.s1 = {trail_signal_fail, rx_overhead_bits, rx_frame_start_tick,
                    multiframe_start_tick, frame_start_tick, frame_clk};
        s_nxt.s2 = s_r.s1;
        s_nxt.clk_prev = s_r.s2[`SI_FCLK];
        fedge = s_r.s2[`SI_FCLK] & ~s_r.clk_prev;

        marker  = s_r.ctrl[`CTRL_MARKER];
        ssm_dis = s_r.ctrl[`CTRL_SSM_DIS];
        ql_en   = s_r.ctrl[`CTRL_QL_EN];
        supp    = s_r.ctrl[`CTRL_SSM_SUPP];

        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid) begin
            s_nxt.bresp = `RESP_OKAY;
            case (reg_decode(s_nxt.awaddr))
                2'd0: if (s_nxt.wstrb[0]) s_nxt.ctrl = s_nxt.wdata[`CTRL_W-1:0];
                2'd1: if (s_nxt.wstrb[0]) s_nxt.csid = s_nxt.wdata[`CSID_W-1:0];
                2'd2: s_nxt.bresp = `RESP_OKAY;   // status is read-only, write ignored
                default: s_nxt.bresp = `RESP_SLVERR;
            endcase
            s_nxt.bvalid = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
        end
        // one write at a time: hold both channels until the response is gone
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

        // read channel: data captured at the address edge
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `RESP_OKAY;
            s_nxt.rdata  = 32'h0000_0000;
            case (reg_decode(s_axi_araddr))
                2'd0: s_nxt.rdata[`CTRL_W-1:0] = s_r.ctrl;
                2'd1: s_nxt.rdata[`CSID_W-1:0] = s_r.csid;
                2'd2: s_nxt.rdata[7:0] = {1'b0, s_r.ql_out, s_r.ssf, s_r.cause, s_r.defect, s_r.align};
                default: s_nxt.rresp = `RESP_SLVERR;
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;

        // ********************************************************
        // source
        // ********************************************************

        forced   = !ql_en || (remote_clock_source_id == clock_source_id) || ssm_dis;
        new_code = ssm_encode(quality_level_in);
        new_mark = (quality_level_in == primary_reference_level) ? `TM_PRC : `TM_OTHER;
        if (forced) begin
            new_code = `SSM_FORCED;
            new_mark = 1'b1;
        end
        if (fedge && s_r.s2[`SI_TXFS]) begin
            // indicator is the plain frame index, shared by any parallel generator
            fidx = s_r.s2[`SI_TXMFS] ? 2'd0 : s_r.tx_idx + 2'd1;
            s_nxt.tx_idx = fidx;
            // code only changes at the boundary
            code_use = (fidx == 2'd0) ? new_code : s_r.tx_code;
            if (fidx == 2'd0) begin
                s_nxt.tx_code = new_code;
            end
            if (marker) begin
                s_nxt.tx_ma = {2'b00, new_mark};
            end else begin
                s_nxt.tx_ma = {fidx, code_use[2'd3 - fidx]};
            end
        end

        // ********************************************************
        // sink
        // ********************************************************

        sink_en = ql_en && supp && !marker;
        mark_en = ql_en && supp && marker;
        ind = s_r.s2[`SI_RXMA+2 -: 2];
        b8  = s_r.s2[`SI_RXMA];
        seq_ok = (ind == s_r.rx_last + 2'd1);
        rx_code = {s_r.rx_shift, b8};

        if (!sink_en) begin
            s_nxt.align  = out_of_multiframe_state;
            s_nxt.ok_cnt = 3'd0;
        end else if (fedge && s_r.s2[`SI_RXFS]) begin
            s_nxt.rx_last = ind;
            // bit 8 collected as code bits
            s_nxt.rx_shift = rx_code[2:0];
            if (s_r.align == in_multiframe_state) begin
                if (!seq_ok) begin
                    s_nxt.align  = out_of_multiframe_state;
                    s_nxt.ok_cnt = 3'd0;
                end
            end else begin
                s_nxt.ok_cnt = seq_ok ? s_r.ok_cnt + 3'd1 : 3'd0;
                if (seq_ok && (s_r.ok_cnt + 3'd1 == `ALIGN_FRAMES)) begin
                    s_nxt.align = in_multiframe_state;
                end
            end
            if (s_nxt.align == in_multiframe_state && ind == `LAST_FRAME) begin
                if (rx_code == s_r.cand_code) begin
                    if (s_r.code_hits != `ACCEPT_HITS) s_nxt.code_hits = s_r.code_hits + 2'd1;
                end else begin
                    s_nxt.cand_code = rx_code;
                    s_nxt.code_hits = 2'd1;
                end
                if (s_nxt.code_hits == `ACCEPT_HITS) s_nxt.acc_code = s_nxt.cand_code;
            end
        end

        if (mark_en && fedge && s_r.s2[`SI_RXFS]) begin
            if (b8 == s_r.cand_mark) begin
                if (s_r.mark_hits != `ACCEPT_HITS) s_nxt.mark_hits = s_r.mark_hits + 2'd1;
            end else begin
                s_nxt.cand_mark = b8;
                s_nxt.mark_hits = 2'd1;
            end
            if (s_nxt.mark_hits == `ACCEPT_HITS) s_nxt.acc_mark = s_nxt.cand_mark;
        end

        if (!ql_en || !supp) begin
            s_nxt.ql_out = quality_not_supported;
        end else if (marker) begin
            // a set marker only says "not primary"; report the lowest level it covers
            s_nxt.ql_out = (s_r.acc_mark == `TM_PRC) ? primary_reference_level : equipment_clock_level;
        end else begin
            s_nxt.ql_out = ssm_decode(s_r.acc_code);
        end

        if (sink_en && s_r.align == out_of_multiframe_state) begin
            if (s_r.lom_cnt == LOM_LAST) begin
                s_nxt.defect = 1'b1;
            end else begin
                s_nxt.lom_cnt = s_r.lom_cnt + `LOM_CNT_W'(1);
            end
        end else begin
            s_nxt.lom_cnt = '0;
        end
        if (!sink_en || s_nxt.align == in_multiframe_state) begin
            s_nxt.defect = 1'b0;
        end

        s_nxt.ssf = s_r.defect | s_r.s2[`SI_TSF];
        s_nxt.cause = s_r.defect & ~s_r.s2[`SI_TSF];
        s_nxt.cs_out  = s_r.csid;
        s_nxt.rcs_out = s_r.csid;
        // clock pass-through, three register stages late (two sync stages and the output register)
        s_nxt.ck_out = s_r.s2[`SI_FCLK];
    end

    // ************************************************************
    // registers
    // ************************************************************

    // reset loads constants only; accepted code starts as the all-ones pattern
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r           <= '0;
            s_r.ctrl      <= `CTRL_RST;
            s_r.csid      <= `CSID_RST;
            s_r.tx_code   <= `SSM_FORCED;
            s_r.tx_ma     <= 3'b001;
            s_r.acc_code  <= `SSM_FORCED;
            s_r.cand_code <= `SSM_FORCED;
            s_r.acc_mark  <= 1'b1;
            s_r.cand_mark <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready               = s_r.awready;
    assign s_axi_wready                = s_r.wready;
    assign s_axi_bvalid                = s_r.bvalid;
    assign s_axi_bresp                 = s_r.bresp;
    assign s_axi_arready               = s_r.arready;
    assign s_axi_rvalid                = s_r.rvalid;
    assign s_axi_rdata                 = s_r.rdata;
    assign s_axi_rresp                 = s_r.rresp;
    assign tx_overhead_bits            = s_r.tx_ma;
    assign quality_level_out           = s_r.ql_out;
    assign sink_clock_source_id        = s_r.cs_out;
    assign sink_remote_clock_source_id = s_r.rcs_out;
    assign server_signal_fail_out      = s_r.ssf;
    assign sync_clock_out              = s_r.ck_out;
    assign multiframe_loss_cause       = s_r.cause;
    assign multiframe_loss_defect      = s_r.defect;
    assign in_multiframe               = s_r.align;

endmodule // sync_status_overhead_adapt

// ---- src/ssm_consts.svh ----
// offsets, field positions, reset values, codes and timing counts of the status overhead adapter
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// register bus
`define AXI_AW          8
`define REG_CTRL        8'h00
`define REG_CSID        8'h04
`define REG_STATUS      8'h08
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// control register fields
`define CTRL_MARKER     0
`define CTRL_SSM_DIS    1
`define CTRL_QL_EN      2
`define CTRL_SSM_SUPP   3
`define CTRL_W          4
`define CTRL_RST        4'h0

// clock source identifier width and reset value
`define CSID_W          8
`define CSID_RST        8'h00

// positions in the input synchroniser vector
`define SI_FCLK         0
`define SI_TXFS         1
`define SI_TXMFS        2
`define SI_RXFS         3
`define SI_RXMA         4
`define SI_TSF          7
`define SI_W            8

// status codes and timing marker values
`define SSM_PRC         4'h2
`define SSM_SSUT        4'h4
`define SSM_SSUL        4'h8
`define SSM_SEC         4'hb
`define SSM_FORCED      4'hf
`define TM_PRC          1'b0
`define TM_OTHER        1'b1

// alignment and acceptance counts
`define ALIGN_FRAMES    3'd4
`define ACCEPT_HITS     2'd3
`define LAST_FRAME      2'd3

// loss-of-multiframe time, fixed inside the allowed 1 ms to 5 ms span
`define LOM_TIME_US     3000
`define REF_CLK_MHZ     250
`define LOM_CNT_W       20

`endif

// ---- src/ssm_pkg.sv ----
// types of the status overhead adapter
package ssm_pkg;
`include "ssm_consts.svh"

    // quality levels crossing to and from the distribution layer
    typedef enum logic [2:0] {
        quality_not_supported   = 3'b000,
        primary_reference_level = 3'b001,
        transit_node_level      = 3'b010,
        local_node_level        = 3'b011,
        equipment_clock_level   = 3'b100,
        quality_unknown         = 3'b101
    } ql_t;

    // multiframe alignment states
    typedef enum logic {
        out_of_multiframe_state = 1'b0,
        in_multiframe_state     = 1'b1
    } align_t;

    // the whole state of the adapter
    typedef struct packed {
        logic [`SI_W-1:0]      s1;
        logic [`SI_W-1:0]      s2;
        logic                  clk_prev;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  aw_got;
        logic                  w_got;
        logic [`AXI_AW-1:0]    awaddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  arready;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic [`CTRL_W-1:0]    ctrl;
        logic [`CSID_W-1:0]    csid;
        logic [1:0]            tx_idx;
        logic [3:0]            tx_code;
        logic [2:0]            tx_ma;
        align_t                align;
        logic [1:0]            rx_last;
        logic [2:0]            ok_cnt;
        logic [2:0]            rx_shift;
        logic [3:0]            cand_code;
        logic [1:0]            code_hits;
        logic [3:0]            acc_code;
        logic                  cand_mark;
        logic [1:0]            mark_hits;
        logic                  acc_mark;
        logic [`LOM_CNT_W-1:0] lom_cnt;
        logic                  defect;
        ql_t                   ql_out;
        logic [`CSID_W-1:0]    cs_out;
        logic [`CSID_W-1:0]    rcs_out;
        logic                  ssf;
        logic                  cause;
        logic                  ck_out;
    } state_t;

endpackage

// ---- tb/sync_status_overhead_adapt_monitor.sv ----
// port checker of the status overhead adapter
`timescale 1ns/1ps
module sync_status_overhead_adapt_monitor #(
    parameter int LOM_CYCLES = 750000
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       resetn,
    // watched pins
    input wire logic       frame_clk,
    input wire logic       trail_signal_fail,
    input wire logic [2:0] tx_overhead_bits,
    input wire logic [7:0] sink_clock_source_id,
    input wire logic [7:0] sink_remote_clock_source_id,
    input wire logic       server_signal_fail_out,
    input wire logic       sync_clock_out,
    input wire logic       multiframe_loss_cause,
    input wire logic       multiframe_loss_defect,
    input wire logic       in_multiframe
);
    int         oom_cnt;
    logic [1:0] mi;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    assign mi = tx_overhead_bits[2:1];
    // length of the current unaligned stretch, saturating so it never wraps
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) oom_cnt <= 0;
        else if (in_multiframe) oom_cnt <= 0;
        else if (oom_cnt < LOM_CYCLES) oom_cnt <= oom_cnt + 1;
    end
    property p_tx_step;
        $changed(mi) && mi != 2'd0 && $past(mi) != 2'd0 |-> mi == $past(mi) + 2'd1;
    endproperty
    a_tx_step: assert property (p_tx_step) else $error("indicator skipped");
    // leaving frame index 3 always lands on 0, by wrap or by marker mode
    property p_tx_wrap;
        $changed(mi) && $past(mi) == 2'd3 |-> mi == 2'd0;
    endproperty
    a_tx_wrap: assert property (p_tx_wrap) else $error("indicator did not wrap");
    property p_tx_hold;
        $changed(tx_overhead_bits) |=> $stable(tx_overhead_bits) [*8];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("overhead changed mid frame");
    property p_ids;
        sink_clock_source_id == sink_remote_clock_source_id;
    endproperty
    a_ids: assert property (p_ids) else $error("source ids differ");
    property p_lom_time;
        $rose(multiframe_loss_defect) |-> oom_cnt >= LOM_CYCLES - 2;
    endproperty
    a_lom_time: assert property (p_lom_time) else $error("defect too early");
    property p_lom_exit;
        $rose(in_multiframe) |-> ##[0:1] !multiframe_loss_defect;
    endproperty
    a_lom_exit: assert property (p_lom_exit) else $error("defect kept when aligned");
    property p_ssf_defect;
        multiframe_loss_defect |-> ##[0:1] server_signal_fail_out;
    endproperty
    a_ssf_defect: assert property (p_ssf_defect) else $error("fail low with defect");
    property p_ssf_tsf;
        trail_signal_fail [*4] |-> server_signal_fail_out;
    endproperty
    a_ssf_tsf: assert property (p_ssf_tsf) else $error("fail low with trail fail");
    property p_cause;
        multiframe_loss_cause |-> multiframe_loss_defect || $past(multiframe_loss_defect)
            && !(trail_signal_fail && $past(trail_signal_fail, 3));
    endproperty
    a_cause: assert property (p_cause) else $error("cause without defect");
    property p_cause_tsf;
        trail_signal_fail [*4] |-> !multiframe_loss_cause;
    endproperty
    a_cause_tsf: assert property (p_cause_tsf) else $error("cause under trail fail");
    property p_ck;
        $changed(sync_clock_out) |-> sync_clock_out == $past(frame_clk, 3);
    endproperty
    a_ck: assert property (p_ck) else $error("clock not passed");
endmodule // sync_status_overhead_adapt_monitor
bind sync_status_overhead_adapt sync_status_overhead_adapt_monitor #(.LOM_CYCLES(LOM_CYCLES))
    sync_status_overhead_adapt_monitor_inst (.ref_clk, .resetn, .frame_clk, .trail_signal_fail,
    .tx_overhead_bits, .sink_clock_source_id, .sink_remote_clock_source_id, .server_signal_fail_out,
    .sync_clock_out, .multiframe_loss_cause, .multiframe_loss_defect, .in_multiframe);

// ---- tb/frame_link_model.sv ----
// far-end link model: frame clock, multiframe tick and looped overhead bits
`timescale 1ns/1ps
module frame_link_model (
    // link timing
    output logic             frame_clk,
    output logic             multiframe_start_tick,
    // overhead loop
    input  wire logic [2:0]  tx_bits,
    input  wire logic        corrupt,
    output logic [2:0]       rx_bits
);
    logic [1:0] idx_r  = 2'd0;
    logic       fclk_r = 1'b0;
    logic [2:0] rx_r   = 3'b000;
    // free running 125 ns frame clock, offset so no edge meets a ref_clk rising edge
    initial begin
        #0.25;
        forever #62.5 fclk_r = ~fclk_r;
    end
    // launch on the falling edge so the sampling edge sees settled levels
    always @(negedge fclk_r) begin
        idx_r <= idx_r + 2'd1;
        rx_r <= corrupt ? {2'b00, tx_bits[0]} : tx_bits; // stuck indicator breaks alignment
    end
    assign frame_clk = fclk_r;
    assign rx_bits = rx_r;
    assign multiframe_start_tick = (idx_r == 2'd0);
endmodule // frame_link_model

// ---- tb/sync_status_overhead_adapt_tb.sv ----
// self-checking testbench of the status overhead adapter
`timescale 1ns/1ps
module sync_status_overhead_adapt_tb;
    import ssm_pkg::*;
    logic        ref_clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        tsf = 1'b0, corrupt = 1'b0, bready = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cid = 8'h00, rcid = 8'h01, scid, srcid;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic        awready, wready, bvalid, arready, rvalid, fclk, mfs, sck, ssf, cause, dfct, inmf;
    logic [1:0]  bresp, rresp;
    logic [2:0]  txb, rxb;
    ql_t         qin = primary_reference_level, qout;
    ql_t         lv[4] = '{primary_reference_level, transit_node_level, local_node_level, equipment_clock_level};
    logic [33:0] exp_q[$];
    int          n_fail = 0, total_checks = 0, cyc = 0;
    integer      seed = 32'hbabcc339;
    always #2 ref_clk = ~ref_clk;
    sync_status_overhead_adapt #(.LOM_CYCLES(200)) sync_status_overhead_adapt_inst (
        .ref_clk(ref_clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_clk(fclk),
        .frame_start_tick(1'b1), .multiframe_start_tick(mfs), .quality_level_in(qin), .clock_source_id(cid),
        .remote_clock_source_id(rcid), .tx_overhead_bits(txb), .rx_frame_start_tick(1'b1),
        .rx_overhead_bits(rxb), .trail_signal_fail(tsf), .quality_level_out(qout),
        .sink_clock_source_id(scid), .sink_remote_clock_source_id(srcid), .server_signal_fail_out(ssf),
        .sync_clock_out(sck), .multiframe_loss_cause(cause), .multiframe_loss_defect(dfct),
        .in_multiframe(inmf));
    frame_link_model frame_link_model_inst (.frame_clk(fclk), .multiframe_start_tick(mfs),
        .tx_bits(txb), .corrupt(corrupt), .rx_bits(rxb));
    // compare and count
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // write: both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk({32'h0, bresp}, {32'h0, r});
    endtask
    // read: expectation queued, result compared by the watcher below
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
    endtask
    task automatic wf(input int n);
        repeat (n * 32) @(posedge ref_clk);
    endtask
    // read data watcher
    always @(posedge ref_clk) begin
        if (rvalid === 1'b1) chk({rresp, rdata}, exp_q.pop_front());
    end
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        // response readies stay up, so every answer is taken at the edge it is seen
        bready <= 1'b1;
        rready <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(8'h00, 34'h0);
        rd(8'h04, 34'h0);
        rd(8'h0c, {2'b10, 32'h0});
        wr(8'h0c, 32'hf, 2'b10);
        wr(8'h08, 32'hf, 2'b00);
        v = $random(seed) & 32'hff;
        cid <= v[7:0];
        rcid <= ~v[7:0];
        wr(8'h04, v, 2'b00);
        rd(8'h04, {2'b00, v});
        chk({26'h0, scid}, {26'h0, v[7:0]});
        chk({26'h0, srcid}, {26'h0, v[7:0]});
        wr(8'h00, 32'hc, 2'b00);
        foreach (lv[i]) begin
            qin <= lv[i];
            wf(28);
            rd(8'h08, {27'h0, lv[i], 4'h1});
        end
        rcid <= v[7:0];
        wf(28);
        rd(8'h08, {27'h0, quality_unknown, 4'h1});
        rcid <= ~v[7:0];
        wr(8'h00, 32'he, 2'b00);
        wf(28);
        rd(8'h08, {27'h0, quality_unknown, 4'h1});
        wr(8'h00, 32'hd, 2'b00);
        qin <= primary_reference_level;
        wf(12);
        rd(8'h08, {27'h0, primary_reference_level, 4'h0});
        qin <= transit_node_level;
        wf(12);
        rd(8'h08, {27'h0, equipment_clock_level, 4'h0});
        wr(8'h00, 32'hc, 2'b00);
        wf(28);
        corrupt <= 1'b1;
        wf(12);
        rd(8'h08, {27'h0, transit_node_level, 4'he});
        tsf <= 1'b1;
        wf(1);
        rd(8'h08, {27'h0, transit_node_level, 4'ha});
        corrupt <= 1'b0;
        wf(8);
        rd(8'h08, {27'h0, transit_node_level, 4'h9});
        tsf <= 1'b0;
        corrupt <= 1'b1;
        wf(12);
        wr(8'h00, 32'h4, 2'b00);
        wf(1);
        rd(8'h08, {27'h0, quality_not_supported, 4'h0});
        // quality disabled: every sent code bit is high
        wr(8'h00, 32'h8, 2'b00);
        wf(6);
        repeat (4) begin
            wf(1);
            chk({33'h0, txb[0]}, 34'h1);
        end
        final_report();
    end
endmodule // sync_status_overhead_adapt_tb
